// >>> icta_baud.sv
`timescale 1ns/1ps
// Serial clock divider: quarter-bit and bit enables from pclk
module icta_baud (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [7:0] div,
	output logic            qtick,
	output logic            btick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic [1:0] ph;
		logic       q;
		logic       b;
	} icta_baud_st_t;

	icta_baud_st_t s;
	icta_baud_st_t next_s;

	// Quarter every div+1 cycles, bit every four quarters
	// Settings below the minimum are not guarded, software keeps to it
	always_comb begin
		next_s = s;
		next_s.q = 1'b0;
		next_s.b = 1'b0;
		if (!run) begin
			next_s.cnt = 8'h00;
			next_s.ph = 2'h0;
		end else if (s.cnt >= div) begin
			next_s.cnt = 8'h00;
			next_s.q = 1'b1;
			next_s.ph = s.ph + 2'h1;
			next_s.b = (s.ph == icta_pkg::PH_LAST);
		end else begin
			next_s.cnt = s.cnt + 8'h01;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign qtick = s.q;
	assign btick = s.b;

	AST_BAUD_BIT: assert property (@(posedge pclk) disable iff (!presetn) s.b |-> s.q)
		else $error("bit tick without quarter tick");
endmodule // icta_baud

// >>> icta_match.sv
`timescale 1ns/1ps
// Own-address comparator, combinational
module icta_match #(
	parameter int N  = 4,
	parameter int IW = 2
) (
	input  wire logic [N-1:0][7:0] own_addr,
	input  wire logic [N-1:0][6:0] addr_mask,
	input  wire logic [6:0]        rx_addr,
	output logic                   hit,
	output logic [IW-1:0]          hit_idx,
	output logic                   gc
);
	logic [N-1:0] eq;
	logic [N-1:0] gce;

	// Per entry: masked compare of bits 7:1, general call via bit 0
	for (genvar i = 0; i < N; i++) begin : g_ent
		assign eq[i] = (((own_addr[i][7:1] ^ rx_addr) & ~addr_mask[i]) == 7'h00)
			&& (rx_addr != icta_pkg::GC_ADDR);
		assign gce[i] = own_addr[i][0] && (rx_addr == icta_pkg::GC_ADDR);
	end

	// Any entry answers; lowest index reported
	always_comb begin
		hit = |eq;
		gc = |gce;
		hit_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (eq[i] || gce[i])
				hit_idx = IW'(i);
		end
	end
endmodule // icta_match

// >>> icta_peer.sv
`timescale 1ns/1ps
// Far-side stand-in: completes bus actions and hands over received addresses
module icta_peer (
	input  wire logic  pclk,
	output logic       bus_done,
	output logic [4:0] status_code,
	output logic       rx_addr_valid,
	output logic [6:0] rx_addr
);
	// Quiet at time zero
	initial begin
		bus_done      = 1'b0;
		status_code   = 5'h00;
		rx_addr_valid = 1'b0;
		rx_addr       = 7'h00;
	end

	// One-cycle completion pulse carrying the new status code
	task automatic finish_action(input logic [4:0] code);
		@(posedge pclk);
		bus_done    <= 1'b1;
		status_code <= code;
		@(posedge pclk);
		bus_done    <= 1'b0;
		status_code <= ~code; // Code is only valid with the pulse
	endtask

	// Address byte received; lines move on so a stale value cannot match
	task automatic deliver_address(input logic [6:0] a);
		@(posedge pclk);
		rx_addr_valid <= 1'b1;
		rx_addr       <= a;
		@(posedge pclk);
		rx_addr_valid <= 1'b0;
		rx_addr       <= ~a;
	endtask
endmodule // icta_peer

// >>> icta_pkg.sv
package icta_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_ADDR0 = 8'h04;
	localparam logic [7:0] OFF_STAT  = 8'h0c;
	localparam logic [7:0] OFF_DIV   = 8'h10;
	localparam logic [7:0] OFF_TOC   = 8'h14;
	localparam logic [7:0] OFF_ADDR1 = 8'h18;
	localparam logic [7:0] OFF_ADDR2 = 8'h1c;
	localparam logic [7:0] OFF_ADDR3 = 8'h20;
	localparam logic [7:0] OFF_MASK0 = 8'h24;
	localparam logic [7:0] OFF_MASK1 = 8'h28;
	localparam logic [7:0] OFF_MASK2 = 8'h2c;
	localparam logic [7:0] OFF_MASK3 = 8'h30;
	localparam logic [7:0] OFF_ISTAT = 8'h34;
	localparam logic [7:0] OFF_IMASK = 8'h38;
	// Field positions
	localparam int CTRL_IE  = 7;
	localparam int CTRL_SEF = 3;
	localparam int TOC_EN   = 2;
	localparam int TOC_PRE  = 1;
	localparam int TOC_FLAG = 0;
	localparam int IRQ_TO   = 0;
	localparam int IRQ_SE   = 1;
	localparam int IRQ_AM   = 2;
	localparam int STAT_LSB = 3;
	// Reset values and constants
	localparam logic [4:0] STAT_IDLE = 5'h1f;
	localparam logic [7:0] DIV_RST   = 8'h00;
	localparam logic [1:0] PH_LAST   = 2'h3;
	localparam logic [1:0] PRE_LAST  = 2'h3;
	localparam logic [6:0] GC_ADDR   = 7'h00;
	localparam logic [7:0] DIV_MIN   = 8'h04;
endpackage

// >>> icta_top.sv
`timescale 1ns/1ps
module icta_top #(
	parameter int TW = 14
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        master_mode,
	input  wire logic        bus_done,
	input  wire logic [4:0]  status_code,
	input  wire logic        rx_addr_valid,
	input  wire logic [6:0]  rx_addr,
	output logic             irq,
	output logic             serial_event_flag,
	output logic             timeout_flag,
	output logic             scl_quarter_tick,
	output logic             scl_bit_tick,
	output logic             slave_hit,
	output logic [1:0]       slave_hit_idx,
	output logic             gc_hit
);
	typedef struct packed {
		logic [3:0][7:0] own_address;
		logic [3:0][6:0] address_mask;
		logic [7:0]      clock_divider_value;
		logic            timeout_enable;
		logic            timeout_prescale;
		logic            timeout_flag;
		logic            interrupt_enable;
		logic            sef;
		logic [4:0]      code;
		logic [2:0]      ist;
		logic [2:0]      imask;
		logic [TW-1:0]   to_cnt;
		logic [1:0]      pre;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
		logic            irq;
		logic            hit;
		logic [1:0]      hit_idx;
		logic            gc;
	} icta_top_st_t;

	icta_top_st_t s;
	icta_top_st_t next_s;
	logic         m_hit;
	logic [1:0]   m_idx;
	logic         m_gc;
	logic         setup;
	logic         wr;
	logic         counting;
	logic         to_tick;

	// Bit-rate enables only while this end drives the clock
	icta_baud u_baud (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (master_mode),
		.div     (s.clock_divider_value),
		.qtick   (scl_quarter_tick),
		.btick   (scl_bit_tick)
	);

	// Address comparator over the four own-address entries
	icta_match #(.N(4), .IW(2)) u_match (
		.own_addr  (s.own_address),
		.addr_mask (s.address_mask),
		.rx_addr   (rx_addr),
		.hit       (m_hit),
		.hit_idx   (m_idx),
		.gc        (m_gc)
	);

	// Bus phase decode; pready is high only in the access cycle
	assign setup = psel && !penable;
	assign wr = psel && penable && s.pready && pwrite;
	assign counting = s.timeout_enable && !s.sef;
	assign to_tick = !s.timeout_prescale || (s.pre == icta_pkg::PRE_LAST);

	// Next-state logic for registers, time-out, flags and bus answer
	always_comb begin
		logic [31:0] rd;
		logic        mapped;
		logic        to_set;
		logic        addr_ev;
		logic [2:0]  ev;
		logic [2:0]  iclr;
		rd = 32'h0000_0000;
		mapped = 1'b1;
		to_set = 1'b0;
		addr_ev = 1'b0;
		ev = 3'h0;
		iclr = 3'h0;
		next_s = s;

		// Read mux, narrow registers zero-extended
		case (paddr)
			icta_pkg::OFF_CTRL: begin
				rd[icta_pkg::CTRL_IE] = s.interrupt_enable;
				rd[icta_pkg::CTRL_SEF] = s.sef;
			end
			icta_pkg::OFF_ADDR0: rd[7:0] = s.own_address[0];
			icta_pkg::OFF_ADDR1: rd[7:0] = s.own_address[1];
			icta_pkg::OFF_ADDR2: rd[7:0] = s.own_address[2];
			icta_pkg::OFF_ADDR3: rd[7:0] = s.own_address[3];
			icta_pkg::OFF_MASK0: rd[7:1] = s.address_mask[0];
			icta_pkg::OFF_MASK1: rd[7:1] = s.address_mask[1];
			icta_pkg::OFF_MASK2: rd[7:1] = s.address_mask[2];
			icta_pkg::OFF_MASK3: rd[7:1] = s.address_mask[3];
			icta_pkg::OFF_STAT: rd[7:icta_pkg::STAT_LSB] = s.code;
			icta_pkg::OFF_DIV: rd[7:0] = s.clock_divider_value;
			icta_pkg::OFF_TOC: begin
				rd[icta_pkg::TOC_EN] = s.timeout_enable;
				rd[icta_pkg::TOC_PRE] = s.timeout_prescale;
				rd[icta_pkg::TOC_FLAG] = s.timeout_flag;
			end
			icta_pkg::OFF_ISTAT: rd[2:0] = s.ist;
			icta_pkg::OFF_IMASK: rd[2:0] = s.imask;
			default: mapped = 1'b0;
		endcase

		// Answer is prepared in setup so access completes at once
		next_s.pready = setup;
		next_s.pslverr = setup && !mapped;
		if (setup && !pwrite)
			next_s.prdata = rd;

		// Register writes; reserved bits are dropped
		if (wr) begin
			case (paddr)
				icta_pkg::OFF_CTRL: next_s.interrupt_enable = pwdata[icta_pkg::CTRL_IE];
				icta_pkg::OFF_ADDR0: next_s.own_address[0] = pwdata[7:0];
				icta_pkg::OFF_ADDR1: next_s.own_address[1] = pwdata[7:0];
				icta_pkg::OFF_ADDR2: next_s.own_address[2] = pwdata[7:0];
				icta_pkg::OFF_ADDR3: next_s.own_address[3] = pwdata[7:0];
				icta_pkg::OFF_MASK0: next_s.address_mask[0] = pwdata[7:1];
				icta_pkg::OFF_MASK1: next_s.address_mask[1] = pwdata[7:1];
				icta_pkg::OFF_MASK2: next_s.address_mask[2] = pwdata[7:1];
				icta_pkg::OFF_MASK3: next_s.address_mask[3] = pwdata[7:1];
				icta_pkg::OFF_DIV: next_s.clock_divider_value = pwdata[7:0];
				icta_pkg::OFF_TOC: begin
					next_s.timeout_enable = pwdata[icta_pkg::TOC_EN];
					next_s.timeout_prescale = pwdata[icta_pkg::TOC_PRE];
				end
				icta_pkg::OFF_IMASK: next_s.imask = pwdata[2:0];
				default: ;
			endcase
		end

		// Time-out counter held at zero while disabled or serial event flag pending
		if (!counting) begin
			next_s.to_cnt = '0;
			next_s.pre = 2'h0;
		end else begin
			next_s.pre = s.timeout_prescale ? s.pre + 2'h1 : 2'h0;
			if (to_tick) begin
				next_s.to_cnt = s.to_cnt + 1'b1;
				to_set = &s.to_cnt;
			end
		end

		// Sticky time-out flag; a new expiry beats the one-write clear
		next_s.timeout_flag = (s.timeout_flag && !(wr && paddr == icta_pkg::OFF_TOC
			&& pwdata[icta_pkg::TOC_FLAG])) || to_set;

		// Serial event flag and status code from the protocol engine
		next_s.sef = (s.sef && !(wr && paddr == icta_pkg::OFF_CTRL
			&& pwdata[icta_pkg::CTRL_SEF])) || bus_done;
		if (bus_done)
			next_s.code = status_code;

		// Address recognition only as slave
		addr_ev = rx_addr_valid && !master_mode;
		next_s.hit = addr_ev && m_hit;
		next_s.gc = addr_ev && m_gc;
		if (addr_ev && (m_hit || m_gc))
			next_s.hit_idx = m_idx;

		// Interrupt status, write one to clear, set wins
		ev[icta_pkg::IRQ_TO] = to_set;
		ev[icta_pkg::IRQ_SE] = bus_done;
		ev[icta_pkg::IRQ_AM] = addr_ev && (m_hit || m_gc);
		if (wr && paddr == icta_pkg::OFF_ISTAT)
			iclr = pwdata[2:0];
		next_s.ist = (s.ist & ~iclr) | ev;

		// Level interrupt, gated by the interrupt enable
		next_s.irq = s.interrupt_enable && |(s.ist & s.imask);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.code <= icta_pkg::STAT_IDLE;
			s.clock_divider_value <= icta_pkg::DIV_RST;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state flops
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign irq = s.irq;
	assign serial_event_flag = s.sef;
	assign timeout_flag = s.timeout_flag;
	assign slave_hit = s.hit;
	assign slave_hit_idx = s.hit_idx;
	assign gc_hit = s.gc;

	// Assertions sample on the bus clock and stay quiet while reset is low
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Time-out counter, prescale and sticky flag
	AST_TO_CLEAR: assert property (s.sef |=> s.to_cnt == '0)
		else $error("counter not held while event flag set");
	AST_TO_OFF: assert property (!s.timeout_enable |=> s.to_cnt == '0)
		else $error("counter moved while disabled");
	AST_TO_STEP: assert property ((counting && !s.timeout_prescale && !(&s.to_cnt))
		|=> s.to_cnt == $past(s.to_cnt) + 1'b1)
		else $error("counter did not step");
	AST_TO_PRE: assert property ((counting && s.timeout_prescale
		&& s.pre != icta_pkg::PRE_LAST) |=> s.to_cnt == $past(s.to_cnt))
		else $error("prescaled counter stepped early");
	AST_TO_EXP: assert property ((counting && to_tick && (&s.to_cnt))
		|=> s.timeout_flag && s.to_cnt == '0)
		else $error("overflow did not raise time-out flag");
	AST_TO_W1C: assert property ((s.timeout_flag
		&& !(wr && paddr == icta_pkg::OFF_TOC && pwdata[icta_pkg::TOC_FLAG]))
		|=> s.timeout_flag)
		else $error("time-out flag lost without a clearing write");
	AST_TO_CLR: assert property ((wr && paddr == icta_pkg::OFF_TOC
		&& pwdata[icta_pkg::TOC_FLAG] && !(counting && to_tick && (&s.to_cnt)))
		|=> !s.timeout_flag)
		else $error("time-out flag survived a clearing write");
	AST_TO_IST: assert property ((counting && to_tick && (&s.to_cnt))
		|=> s.ist[icta_pkg::IRQ_TO])
		else $error("time-out not recorded as interrupt source");

	// Interrupt line and serial event flag
	AST_IRQ_EN: assert property (!s.interrupt_enable |=> !s.irq)
		else $error("interrupt raised while disabled");
	AST_IRQ_ON: assert property ((s.interrupt_enable && (|(s.ist & s.imask)))
		|=> s.irq)
		else $error("enabled interrupt not raised");
	AST_SEF: assert property (bus_done |=> s.sef && s.code == $past(status_code))
		else $error("event flag or status code not updated");
	AST_SEF_HOLD: assert property ((s.sef
		&& !(wr && paddr == icta_pkg::OFF_CTRL && pwdata[icta_pkg::CTRL_SEF])) |=> s.sef)
		else $error("serial event flag lost without a clearing write");

	// Address recognition, checked against the register fields
	AST_MASTER: assert property (master_mode |=> !s.hit && !s.gc)
		else $error("address match in master mode");
	AST_ADDR_EXACT: assert property ((rx_addr_valid && !master_mode
		&& rx_addr != icta_pkg::GC_ADDR && rx_addr == s.own_address[2][7:1]) |=> s.hit)
		else $error("exact own address not recognised");
	AST_ADDR_MASK: assert property ((rx_addr_valid && !master_mode
		&& rx_addr != icta_pkg::GC_ADDR
		&& ((rx_addr ^ s.own_address[0][7:1]) & ~s.address_mask[0]) == 7'h00) |=> s.hit)
		else $error("masked own address not recognised");
	AST_HIT_IDX: assert property ((rx_addr_valid && !master_mode && m_hit)
		|=> s.hit && s.hit_idx == $past(m_idx))
		else $error("address hit or entry index not reported");
	AST_GC_ON: assert property ((rx_addr_valid && !master_mode
		&& rx_addr == icta_pkg::GC_ADDR && s.own_address[3][0]) |=> s.gc)
		else $error("general call not recognised while enabled");
	AST_GC_OFF: assert property ((rx_addr_valid && rx_addr == icta_pkg::GC_ADDR
		&& !(s.own_address[0][0] || s.own_address[1][0] || s.own_address[2][0]
		|| s.own_address[3][0])) |=> !s.gc)
		else $error("general call recognised while disabled");

	// Bus answer: one access cycle, reserved read bits stay zero
	AST_RSV_ZERO: assert property (s.prdata[31:8] == 24'h000000)
		else $error("reserved read bits not zero");
	AST_APB: assert property (setup |=> s.pready ##1 !s.pready)
		else $error("bus answer timing wrong");
endmodule // icta_top

// >>> tb_i2c_clock_timeout_address.sv
`timescale 1ns/1ps
module tb_i2c_clock_timeout_address;
	localparam int         TW = 4;
	localparam logic [7:0] OWN_OFFS [4] = '{icta_pkg::OFF_ADDR0, icta_pkg::OFF_ADDR1,
		icta_pkg::OFF_ADDR2, icta_pkg::OFF_ADDR3};
	logic        pclk        = 1'b0;
	logic        presetn     = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0;
	logic        master_mode = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, serial_event_flag, timeout_flag;
	logic        scl_quarter_tick, scl_bit_tick, slave_hit, gc_hit;
	logic        bus_done, rx_addr_valid;
	logic [1:0]  slave_hit_idx;
	logic [4:0]  status_code;
	logic [6:0]  rx_addr;
	logic [32:0] expq [$];
	logic [32:0] note;
	logic [31:0] seed = 32'h49e8;
	int          errors = 0;
	int          n_checks = 0;
	int          n;

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	icta_top #(.TW(TW)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .master_mode(master_mode),
		.bus_done(bus_done), .status_code(status_code), .rx_addr_valid(rx_addr_valid),
		.rx_addr(rx_addr), .irq(irq), .serial_event_flag(serial_event_flag),
		.timeout_flag(timeout_flag), .scl_quarter_tick(scl_quarter_tick),
		.scl_bit_tick(scl_bit_tick), .slave_hit(slave_hit),
		.slave_hit_idx(slave_hit_idx), .gc_hit(gc_hit));

	icta_peer peer_u (.pclk(pclk), .bus_done(bus_done), .status_code(status_code),
		.rx_addr_valid(rx_addr_valid), .rx_addr(rx_addr));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// APB transfer; the note {pslverr, prdata} is queued for the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] exp);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		expq.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			errors++;
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] exp);
		apb(1'b0, a, 32'h0, exp);
	endtask

	// Counts edges until the flag (0), bit tick (1) or quarter tick (2); a timeout ends the run
	task automatic wait_hi(input int s, input int lim, output int cnt);
		for (cnt = 1; cnt <= lim; cnt++) begin
			@(posedge pclk);
			if (((s == 0) ? timeout_flag : (s == 1) ? scl_bit_tick : scl_quarter_tick) === 1'b1)
				break;
		end
		if (cnt > lim) begin
			errors++;
			tally_and_finish();
		end
	endtask

	task automatic in_range(input string what, input int v, input int lo, input int hi);
		chk(what, {31'h0, v >= lo && v <= hi}, 32'h1);
	endtask

	// Monitor retires the oldest note at each completed transfer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
			note = expq.pop_front();
			chk("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
			if (!pwrite)
				chk("prdata", prdata, note[31:0]);
		end
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(icta_pkg::OFF_STAT, 33'h0f8);
		rd(icta_pkg::OFF_DIV, 33'h0);
		rd(icta_pkg::OFF_TOC, 33'h0);
		wr(icta_pkg::OFF_DIV, 32'hffffffff);
		rd(icta_pkg::OFF_DIV, 33'h0ff);
		apb(1'b1, 8'h40, 32'h1, {1'b1, 32'h0});
		rd(8'h40, {1'b1, 32'h0});
		// Random own addresses read back in the low byte only, then cleared
		foreach (OWN_OFFS[k]) begin
			seed = lfsr(seed);
			wr(OWN_OFFS[k], seed);
			rd(OWN_OFFS[k], {25'h0, seed[7:0]});
			wr(OWN_OFFS[k], 32'h0);
		end
		wr(icta_pkg::OFF_DIV, {24'h0, icta_pkg::DIV_MIN});
		master_mode <= 1'b1;
		wait_hi(1, 100, n);
		wait_hi(1, 100, n);
		in_range("bit period", n, 20, 20);
		wait_hi(2, 100, n);
		wait_hi(2, 100, n);
		in_range("quarter period", n, 5, 5);
		// Address recognition: ignored as master, then exact, general call, masked
		wr(icta_pkg::OFF_ADDR2, 32'h6a);
		peer_u.deliver_address(7'h35);
		@(posedge pclk);
		chk("master hit", {31'h0, slave_hit}, 32'h0);
		master_mode <= 1'b0;
		peer_u.deliver_address(7'h35);
		@(posedge pclk);
		chk("hit", {29'h0, slave_hit, slave_hit_idx}, 32'h6);
		peer_u.deliver_address(icta_pkg::GC_ADDR);
		@(posedge pclk);
		chk("gc off", {31'h0, gc_hit}, 32'h0);
		wr(icta_pkg::OFF_ADDR3, 32'h1);
		peer_u.deliver_address(icta_pkg::GC_ADDR);
		@(posedge pclk);
		chk("gc on", {31'h0, gc_hit}, 32'h1);
		wr(icta_pkg::OFF_ADDR0, 32'h20);
		wr(icta_pkg::OFF_MASK0, 32'h0e);
		peer_u.deliver_address(7'h17);
		@(posedge pclk);
		chk("masked hit", {29'h0, slave_hit, slave_hit_idx}, 32'h4);
		// Time-out: 2**TW counts plain, four times as long with prescale
		wr(icta_pkg::OFF_TOC, 32'h4);
		wait_hi(0, 40, n);
		in_range("timeout", n, 14, 20);
		rd(icta_pkg::OFF_TOC, 33'h5);
		wr(icta_pkg::OFF_TOC, 32'h4);
		rd(icta_pkg::OFF_TOC, 33'h5);
		wr(icta_pkg::OFF_TOC, 32'h1);
		rd(icta_pkg::OFF_TOC, 33'h0);
		wr(icta_pkg::OFF_TOC, 32'h6);
		wait_hi(0, 100, n);
		in_range("prescaled timeout", n, 60, 72);
		wr(icta_pkg::OFF_TOC, 32'h1);
		// Pending serial event holds the counter until software clears it
		peer_u.finish_action(5'h0a);
		wr(icta_pkg::OFF_TOC, 32'h4);
		repeat (40) @(posedge pclk);
		chk("held timeout", {31'h0, timeout_flag}, 32'h0);
		chk("serial event", {31'h0, serial_event_flag}, 32'h1);
		rd(icta_pkg::OFF_STAT, 33'h50);
		rd(icta_pkg::OFF_CTRL, 33'h08);
		wr(icta_pkg::OFF_CTRL, 32'h08);
		wait_hi(0, 40, n);
		in_range("resumed timeout", n, 12, 20);
		// Interrupt only with the enable bit; cleared flags drop it
		wr(icta_pkg::OFF_IMASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq disabled", {31'h0, irq}, 32'h0);
		wr(icta_pkg::OFF_CTRL, 32'h80);
		repeat (2) @(posedge pclk);
		chk("irq enabled", {31'h0, irq}, 32'h1);
		wr(icta_pkg::OFF_TOC, 32'h1);
		wr(icta_pkg::OFF_ISTAT, 32'h7);
		repeat (2) @(posedge pclk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		// Serial event as interrupt source once masked in
		wr(icta_pkg::OFF_IMASK, 32'h2);
		peer_u.finish_action(5'h0c);
		repeat (2) @(posedge pclk);
		chk("irq serial event", {31'h0, irq}, 32'h1);
		tally_and_finish();
	end
endmodule // tb_i2c_clock_timeout_address
